/* rtl/beat_fifo.sv */
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
module beat_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_q != DEPTH_C;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule

/* rtl/burst_bus_transfer_sequencer.sv */
/*
  External bus master sequencer for multi-beat word, longword and line
  transfers: address stepping, size codes, start/acknowledge handshake,
  wait states and data bus release. Read beats pass through a FIFO.
  Assumes the slave is synchronous to clk and the testbench resolves
  the data bus from data_oe.
*/
module burst_bus_transfer_sequencer #(
  parameter int FIFO_DEPTH = burst_seq_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input wire burst_seq_pkg::xfer_req_t req,
  input wire burst_seq_pkg::region_cfg_t region_cfg,
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic [burst_seq_pkg::DATA_W-1:0] wd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [burst_seq_pkg::DATA_W-1:0] rd_data,
  output logic busy,
  output logic done,
  // external bus
  output logic [burst_seq_pkg::ADDR_W-1:0] addr,
  output logic xfer_start_n,
  output logic [1:0] xfer_type,
  output logic access_mode_line,
  output logic read_write,
  output logic [1:0] xfer_size,
  output logic [burst_seq_pkg::DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [burst_seq_pkg::DATA_W-1:0] data_i,
  input wire logic xfer_ack_n
);
  import burst_seq_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  xfer_req_t req_q;
  region_cfg_t cfg_q;
  logic burst_q;
  logic [1:0] size_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [BEAT_W-1:0] left_q;
  logic oe_q;
  logic done_q;

  // log2 of operand bytes and port bytes
  function automatic logic [2:0] op_log(input op_size_t s);
    logic [2:0] r;
    r = 3'h0;
    case (s)
      SZ_BYTE: r = 3'h0;
      SZ_WORD: r = 3'h1;
      SZ_LONG: r = 3'h2;
      default: r = 3'h4;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] port_log(input port_width_t p);
    logic [2:0] r;
    r = 3'h2;
    case (p)
      PORT_8: r = 3'h0;
      PORT_16: r = 3'h1;
      default: r = 3'h2;
    endcase
    return r;
  endfunction

  // decode of the incoming request against its region settings
  wire [2:0] in_oplog = op_log(req.size);
  wire [2:0] in_portlog = port_log(region_cfg.port);
  wire in_wider = in_oplog > in_portlog;
  wire [2:0] in_beatlog = in_wider ? 3'(in_oplog - in_portlog) : 3'h0;
  // one to sixteen beats; they burst when the region has burst_en or dram set
  wire [BEAT_W-1:0] in_beats = BEAT_W'(5'h01 << in_beatlog);
  wire in_burst = region_cfg.burst_en || region_cfg.dram;
  // size code: operand in burst mode, narrower of the two otherwise
  wire [1:0] in_size = (in_burst || !in_wider) ? req.size
                     : region_cfg.port;

  // room in the read FIFO is the back-pressure for taking a read request
  logic fifo_in_ready;
  wire is_write = req_q.write;
  wire take_ok = req.write ? wd_valid : fifo_in_ready;
  wire take = state_q == ST_IDLE && req_valid && take_ok;
  wire ack = state_q == ST_DATA && !xfer_ack_n;
  wire last = left_q == BEATS_RST;
  wire next_beat = ack && !last;
  wire inhib_wait = state_q == ST_DATA && !is_write && !last
                    && !fifo_in_ready;

  // address stepping stays inside the operand's aligned block
  wire [2:0] cur_oplog = op_log(op_size_t'(req_q.size));
  wire [2:0] cur_portlog = port_log(cfg_q.port);
  wire [ADDR_W-1:0] step = ADDR_W'(28'h1 << cur_portlog);
  wire [ADDR_W-1:0] blk_mask = ADDR_W'((28'h1 << cur_oplog) - 28'h1);
  wire [ADDR_W-1:0] addr_inc = ADDR_W'(addr_q + step);
  wire [ADDR_W-1:0] addr_next = (addr_q & ~blk_mask)
                              | (addr_inc & blk_mask);

  // read capture: narrow ports land in the low bits
  logic [DATA_W-1:0] cap_data;
  always_comb begin
    cap_data = data_i;
    case (cfg_q.port)
      PORT_8: cap_data = DATA_W'(data_i[LANE8_HI:LANE8_LO]);
      PORT_16: cap_data = DATA_W'(data_i[LANE8_HI:LANE16_LO]);
      default: cap_data = data_i;
    endcase
  end
  wire cap_push = ack && !is_write;

  beat_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) rd_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cap_push),
    .in_ready(fifo_in_ready),
    .in_data(cap_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // state flow: start cycle, then data cycles until the last acknowledge; without burst each beat gets its own start cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        state_d = ST_DATA;
      end
      ST_DATA: begin
        if (ack && last) begin
          state_d = ST_IDLE;
        end else if (next_beat && !burst_q) begin
          state_d = ST_START;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request, region settings and mode latched when taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= '0;
      cfg_q <= '0;
      burst_q <= 1'b0;
      size_q <= SZ_LONG;
    end else if (take) begin
      req_q <= req;
      cfg_q <= region_cfg;
      burst_q <= in_burst;
      size_q <= in_size;
    end
  end

  // address and remaining beats; held while acknowledge is negated
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= ADDR_RST;
      left_q <= BEATS_RST;
    end else if (take) begin
      addr_q <= req.addr;
      left_q <= BEAT_W'(in_beats - 5'h01);
    end else if (next_beat) begin
      addr_q <= addr_next;
      left_q <= BEAT_W'(left_q - 5'h01);
    end
  end

  // write data: one word per beat, next word loaded on acknowledge
  assign wd_ready = (take && req.write) || (next_beat && is_write);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdata_q <= DATA_RST;
    end else if (wd_ready) begin
      wdata_q <= wd_data;
    end
  end

  // data bus enable for writes only, from the second cycle up to the final acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else if (ack && last) begin
      oe_q <= 1'b0;
    end else if (state_q == ST_START && is_write) begin
      oe_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= ack && last;
    end
  end

  // stall_start flags a read start cycle without FIFO room; nothing uses it
  wire stall_start = state_q == ST_START && !is_write && !fifo_in_ready;

  assign req_ready = state_q == ST_IDLE && take_ok;
  assign busy = state_q != ST_IDLE;
  assign done = done_q;
  assign addr = addr_q;
  assign xfer_start_n = !(state_q == ST_START);
  assign xfer_type = (state_q == ST_IDLE) ? TYPE_RST : req_q.xtype;
  assign access_mode_line = (state_q == ST_START) ? req_q.is_code
                          : req_q.supervisor;
  assign read_write = (state_q == ST_IDLE) ? 1'b1 : !is_write;
  assign xfer_size = size_q;
  assign data_o = wdata_q;
  assign data_oe = oe_q;

  // read FIFO room is checked only at take; later read beats are dropped when it is full
  logic unused_ok;
  assign unused_ok = inhib_wait ^ stall_start;

endmodule

/* shared/burst_seq_pkg.sv */
/*
  Package for the burst transfer sequencer: size and port codes, request
  and configuration structs, state encoding and field constants.
  Assumes a single 20 MHz bus clock shared with the external slaves.
*/
package burst_seq_pkg;

  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int BEAT_W = 5;
  localparam int FIFO_DEPTH = 4;

  // codes driven on the size lines
  typedef enum logic [1:0] {
    SZ_LONG = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10,
    SZ_LINE = 2'b11
  } op_size_t;

  // port width of the selected region
  typedef enum logic [1:0] {
    PORT_32 = 2'b00,
    PORT_8 = 2'b01,
    PORT_16 = 2'b10
  } port_width_t;

  // gray codes along idle -> start -> data
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11
  } seq_state_t;

  // byte-lane field of an 8-bit port, upper half of a 16-bit port
  localparam int LANE8_HI = 31;
  localparam int LANE8_LO = 24;
  localparam int LANE16_LO = 16;

  localparam logic [ADDR_W-1:0] ADDR_RST = 28'h0000000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [1:0] TYPE_RST = 2'h0;
  localparam logic [BEAT_W-1:0] BEATS_RST = 5'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    op_size_t size;
    logic write;
    logic [1:0] xtype;
    logic is_code;
    logic supervisor;
  } xfer_req_t;

  // settings of the matching chip-select or default memory region
  typedef struct packed {
    port_width_t port;
    logic burst_en;
    logic dram;
  } region_cfg_t;

endpackage

/* sim/burst_seq_assertions.sv */
/* assertion checker for the burst transfer sequencer
   bound to the sequencer top module, sees its ports only */
module burst_seq_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire burst_seq_pkg::xfer_req_t req,
  input wire burst_seq_pkg::region_cfg_t region_cfg,
  input wire logic busy,
  input wire logic done,
  input wire logic [burst_seq_pkg::ADDR_W-1:0] addr,
  input wire logic xfer_start_n,
  input wire logic [1:0] xfer_type,
  input wire logic access_mode_line,
  input wire logic read_write,
  input wire logic [1:0] xfer_size,
  input wire logic [burst_seq_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe,
  input wire logic xfer_ack_n
);
  import burst_seq_pkg::*;
  xfer_req_t req_q;
  region_cfg_t cfg_q;
  logic take, dcyc, bm;
  assign take = req_valid && req_ready;
  assign dcyc = busy && xfer_start_n;
  assign bm = cfg_q.burst_en || cfg_q.dram;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= '0;
      cfg_q <= '0;
    end else if (take) begin
      req_q <= req;
      cfg_q <= region_cfg;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_take_start: assert property (take |=> !xfer_start_n)
    else $error("no start after request taken");
  chk_start_ctl: assert property (!xfer_start_n |->
    access_mode_line == req_q.is_code && read_write == !req_q.write
    && xfer_type == req_q.xtype) else $error("start cycle controls wrong");
  chk_data_mode: assert property (dcyc |->
    access_mode_line == req_q.supervisor) else $error("mode not privilege");
  chk_write_oe: assert property (!xfer_start_n && !read_write |=>
    data_oe && xfer_start_n) else $error("write data not driven");
  chk_wait_hold: assert property (dcyc && xfer_ack_n |=> dcyc &&
    $stable(addr) && (read_write || $stable(data_o)))
    else $error("beat not held in wait state");
  chk_bus_release: assert property (done |-> !data_oe)
    else $error("data bus not released");
  chk_burst_size: assert property (!xfer_start_n && bm |->
    xfer_size == req_q.size) else $error("burst size code wrong");
  chk_no_line: assert property (!xfer_start_n && !bm |->
    xfer_size != 2'b11) else $error("line code while inhibited");
  chk_burst_nostart: assert property (dcyc && !xfer_ack_n && bm |=>
    xfer_start_n) else $error("start repeated in burst");
  chk_inh_restart: assert property (dcyc && !xfer_ack_n && !bm |=>
    !xfer_start_n || done) else $error("inhibited beat not restarted");
  cover property (!xfer_start_n && xfer_size == 2'b11);
  cover property (dcyc && xfer_ack_n);
  cover property (done && read_write);
endmodule

bind burst_bus_transfer_sequencer burst_seq_chk burst_seq_chk_i (.clk,
  .rst, .req_valid, .req_ready, .req, .region_cfg, .busy, .done, .addr,
  .xfer_start_n, .xfer_type, .access_mode_line, .read_write, .xfer_size,
  .data_o, .data_oe, .xfer_ack_n);

/* sim/bus_slave_model.sv */
/* behavioural slave on the external bus of the sequencer
   port width and burst setting come from the bench per transfer */
module bus_slave_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [burst_seq_pkg::ADDR_W-1:0] addr,
  input wire logic xfer_start_n,
  input wire logic read_write,
  input wire logic [1:0] xfer_size,
  input wire logic [2:0] pbytes,
  input wire logic burst,
  input wire logic [1:0] max_wait,
  output logic [burst_seq_pkg::DATA_W-1:0] data_i,
  output logic xfer_ack_n
);
  import burst_seq_pkg::*;
  int left = 0, wt = 0, ob;
  initial begin
    xfer_ack_n = 1'b1;
    data_i = 32'h0;
  end
  always @(posedge clk) begin
    ob = xfer_size == 2'b01 ? 1 : xfer_size == 2'b10 ? 2 : 16;
    if (xfer_size == 2'b00) ob = 4;
    if (!xfer_ack_n) left = left - 1;
    if (rst) left = 0;
    else if (!xfer_start_n) begin
      left = burst && ob > pbytes ? ob / pbytes : 1;
      wt = $urandom_range(max_wait);
    end else if (!xfer_ack_n) wt = $urandom_range(max_wait);
    else if (wt > 0) wt = wt - 1;
    #1;
    // random wait stands for a slave not ready to take the beat
    xfer_ack_n = !(left > 0 && wt == 0);
    // addressed lanes at the top; released lines toggle
    data_i = !xfer_ack_n && read_write ? {4{addr[7:0]}} ^ 32'h5a3c96e1
      : ~data_i;
  end
endmodule

/* sim/tb_top.sv */
/* self-checking bench for the burst transfer sequencer
   assumes the slave model and the checker compiled before it */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import burst_seq_pkg::*;
  logic clk = 0, rst = 1, req_valid = 0, rd_ready = 1, sb = 0;
  logic req_ready, wd_ready, rd_valid, busy, done, xfer_start_n;
  logic access_mode_line, read_write, data_oe, xfer_ack_n;
  logic [1:0] xfer_type, xfer_size, max_wait = 2'h0;
  logic [2:0] spb = 3'h4;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd_data, rd_data, data_o, data_i;
  logic [63:0] e, st, bt, sq[$], bq[$], rq[$];
  xfer_req_t req = '0;
  region_cfg_t cfg = '0;
  int n_errors = 0, n_compared = 0, cyc = 0, wcnt = 0, wexp = 0;
  function automatic logic [31:0] wpat(int k);
    return k * 32'h01030507 ^ 32'h9e3779b9;
  endfunction
  assign wd_data = wpat(wcnt);
  assign st = {32'h0, addr, xfer_size, read_write, access_mode_line};
  assign bt = {3'h0, access_mode_line, addr, read_write ? 32'h0 : data_o};
  always #25 clk = ~clk;
  burst_bus_transfer_sequencer burst_bus_transfer_sequencer_i (.clk, .rst,
    .req_valid, .req_ready, .req, .region_cfg(cfg), .wd_valid(1'b1),
    .wd_ready, .wd_data, .rd_valid, .rd_ready, .rd_data, .busy, .done,
    .addr, .xfer_start_n, .xfer_type, .access_mode_line, .read_write,
    .xfer_size, .data_o, .data_oe, .data_i, .xfer_ack_n);
  bus_slave_model bus_slave_model_i (.clk, .rst, .addr, .xfer_start_n,
    .read_write, .xfer_size, .pbytes(spb), .burst(sb), .max_wait,
    .data_i, .xfer_ack_n);
  task automatic check(logic [63:0] x, logic [63:0] g);
    n_compared++;
    if (x !== g) begin
      n_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  function automatic logic [63:0] pop(ref logic [63:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 64'hffffffff;
  endfunction
  task automatic end_sim;
    n_errors += sq.size() + bq.size() + rq.size();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (req_valid && req_ready) begin
      spb <= cfg.port == PORT_32 ? 3'h4 : cfg.port == PORT_16 ? 3'h2 : 3'h1;
      sb <= cfg.burst_en | cfg.dram;
    end
    if (wd_ready) wcnt <= wcnt + 1;
    cyc <= cyc + 1;
    if (!rst && !xfer_start_n) check(pop(sq), st);
    if (!rst && busy && xfer_start_n && !xfer_ack_n)
      check(pop(bq), bt);
    if (rd_valid && rd_ready) begin
      e = pop(rq);
      check(e, {e[63:32], rd_data & e[63:32]});
    end
    if (cyc == 5000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic xfer(logic [1:0] sz, logic wr, port_width_t pt, logic bu,
    logic dr);
    int ob, p, i;
    logic [31:0] w, m;
    logic [ADDR_W-1:0] a, b;
    @(posedge clk);
    #1;
    ob = sz == 2'b01 ? 1 : sz == 2'b10 ? 2 : sz == 2'b00 ? 4 : 16;
    p = pt == PORT_32 ? 4 : pt == PORT_16 ? 2 : 1;
    a = ADDR_W'($urandom) & ~ADDR_W'((ob > 4 ? 4 : ob) - 1);
    max_wait = 2'($urandom);
    req = '{a, op_size_t'(sz), wr, 2'($urandom), 1'($urandom), 1'($urandom)};
    cfg = '{pt, bu, dr};
    req_valid = 1;
    m = p == 4 ? 32'hffffffff : p == 2 ? 32'hffff : 32'hff;
    for (i = 0; i < (ob > p ? ob / p : 1); i++) begin
      b = a & ~ADDR_W'(ob - 1) | (a + ADDR_W'(i * p)) & ADDR_W'(ob - 1);
      w = {4{b[7:0]}} ^ 32'h5a3c96e1;
      if (i == 0 || !(bu || dr))
        sq.push_back({32'h0, b, (bu || dr || ob <= p) ? sz : 2'(pt), !wr,
          req.is_code});
      bq.push_back({3'h0, req.supervisor, b, wr ? wpat(wexp) : 32'h0});
      wexp += wr;
      if (!wr) rq.push_back({m, (w >> (32 - 8 * p)) & m});
    end
    do @(posedge clk); while (!req_ready);
    #1 req_valid = 0;
  endtask
  initial begin
    void'($urandom(43436));
    repeat (8) @(posedge clk);
    #1 rst = 0;
    for (int k = 0; k < 36; k++) begin
      xfer(2'(k), k[2], port_width_t'(k / 4 % 3), k[2] & k[3], k[2] & !k[3]);
    end
    wait (!busy);
    repeat (3) @(posedge clk);
    #1 rd_ready = 0;
    xfer(2'b00, 0, PORT_8, 0, 0);
    fork
      xfer(2'b10, 0, PORT_8, 0, 0);
      begin
        repeat (40) @(posedge clk);
        check({63'h0, req_ready}, 64'h0);
        #1 rd_ready = 1;
      end
    join
    wait (!busy);
    repeat (4) @(posedge clk);
    end_sim;
  end
endmodule
